// [hw/spi_eeprom_front.v]
`timescale 1ns/10ps
// What this block does
// R1: master starts every exchange and drives the clock; device is slave.
// R2: chip select high: serial input ignored, output in high impedance.
// R3: incoming bytes shift MSB first, from first rising clock after select.
// R4: read data goes out MSB first from first falling edge after command.
// R5: select falling starts a sequence; first byte is the 8-bit opcode.
// R6: unknown opcode: ignore input, output high-z until next select fall.
// R7: pause does not stop an internal write cycle already running.
// R8: pause entered while selected, pause low during clock low.
// R9: in pause, output high-z, input and clock ignored, protect pin live.
// R10: pause ends when pause input is high during clock low.
// R11: deselect while paused aborts the operation and clears write latch.
// R12: protect pin low with guard bit set refuses status writes.
// R13: protect pin falling while selected cancels a pending status write; code cancels only with guard bit set.
// R14: 05h reads status, 08h is the low-power write poll.
// R15: 06h sets the write latch, 04h clears it.
// R16: 01h writes the status register.
// R17: 03h reads the array, 02h writes the array.
// R18: spare status bits 6:4 read ones while writing, zeros otherwise.
// R19: status bit 0 is busy, one during an internal operation.
// R20: status bit 1 is the write latch, zero after power-up.
// R21: bits 3:2 block guard: 00 none, 01 quarter, 11 whole array.
// R22: bit 7 guard enable, readable and writable, default zero.
// R23: status write changes only bits 7, 3 and 2.
// R24: block guard 10 makes the upper half read-only.
// R25: output stays high-z while selected outside read output phases.
`include "spi_eeprom_defines.vh"

////////////////////////////////////////////////////////////////////////////
// write data buffer: array write bytes with their address
module sync_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 32,
  parameter PW = 5
) (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire clear,
  // filling side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // draining side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0] wr_ptr;
  reg [PW-1:0] rd_ptr;
  reg [PW:0] count;
  wire push;
  wire pop;

  // honest flags straight from the occupancy count
  assign in_ready = (count != DEPTH[PW:0]);
  assign out_valid = (count != {(PW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // storage has no reset; only pointers and count need a defined value
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at DEPTH so depth need not be a power of two
  always @(posedge clk) begin
    if (rst || clear) begin
      wr_ptr <= {PW{1'b0}};
      rd_ptr <= {PW{1'b0}};
      count <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}}
                  : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}}
                  : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// serial front end of the memory
module spi_eeprom_front #(
  parameter AW = 18,
  parameter BUF_DEPTH = 32,
  parameter BUF_PW = 5,
  parameter WRITE_CYCLES = `WRITE_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // serial pins
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire hold_n,
  input wire wp_n,
  output wire so_out,
  output wire so_oe_n,
  // array read side
  output wire [AW-1:0] rd_addr,
  output reg rd_req,
  input wire [7:0] rd_data,
  // array write stream
  output wire [AW-1:0] wr_addr,
  output wire [7:0] wr_data,
  output wire wr_valid,
  input wire wr_ready,
  output wire wbuf_ready,
  output reg array_commit,
  output reg array_abort,
  // state seen by the array
  output wire busy_flag,
  output wire [1:0] block_guard
);
  localparam S_IDLE = 3'h0;
  localparam S_OPC = 3'h1;
  localparam S_ADDR = 3'h2;
  localparam S_OUT = 3'h3;
  localparam S_WDATA = 3'h4;
  localparam S_SRIN = 3'h5;
  localparam S_DONE = 3'h6;
  localparam S_REJECT = 3'h7;

  localparam M_STATUS = 2'h0;
  localparam M_POLL = 2'h1;
  localparam M_ARRAY = 2'h2;

  localparam P_NONE = 2'h0;
  localparam P_SET = 2'h1;
  localparam P_CLEAR = 2'h2;

  // pin order in the synchroniser: cs_n, sck, si, hold_n, wp_n
  reg [4:0] pin_meta;
  reg [4:0] pin_sync;
  reg sck_d;
  reg cs_d;
  reg wp_d;
  reg [2:0] state;
  reg [1:0] omode;
  reg [1:0] pend;
  reg [7:0] sreg;
  reg [2:0] bcnt;
  reg [1:0] acnt;
  reg [AW-1:0] addr;
  reg [7:0] obuf;
  reg [2:0] ocnt;
  reg out_on;
  reg so_q;
  reg hold_act;
  reg wp_fell;
  reg sr_full;
  reg wr_any;
  reg guard_enable_bit;
  reg block_guard_hi;
  reg block_guard_lo;
  reg write_latch;
  reg busy;
  reg [31:0] wcnt;
  reg [7:0] sr_new;
  reg push;
  reg [7:0] push_byte;
  reg [AW-1:0] push_addr;

  wire cs_s = pin_sync[4];
  wire sck_s = pin_sync[3];
  wire si_s = pin_sync[2];
  wire hold_s = pin_sync[1];
  wire wp_s = pin_sync[0];
  wire selected = !cs_s;
  wire cs_fall = cs_d && !cs_s;
  wire cs_rise = !cs_d && cs_s;
  wire live = selected && !cs_d && !hold_act; // R9
  wire sck_rise = live && sck_s && !sck_d; // R3
  wire sck_fall = live && !sck_s && sck_d; // R4
  wire [7:0] in_byte = {sreg[6:0], si_s}; // R3
  wire [7:0] status_flags;
  wire [7:0] out_src;
  wire hw_guard = guard_enable_bit && !wp_s; // R12
  wire addr_guarded;
  wire fifo_in_ready;
  wire [AW+7:0] fifo_out;

  // status layout, rebuilt live so each new byte shows fresh state
  assign status_flags = {guard_enable_bit, {3{busy}}, // R22 R18
                         block_guard_hi, block_guard_lo, // R21
                         write_latch, busy}; // R20 R19
  assign out_src = (omode == M_STATUS) ? status_flags
                 : (omode == M_POLL)
                   ? (busy ? `POLL_BUSY_BYTE : `POLL_READY_BYTE)
                   : rd_data;
  assign busy_flag = busy;
  assign block_guard = {block_guard_hi, block_guard_lo};
  assign rd_addr = addr;

  // block guard decode of the byte address being written
  assign addr_guarded =
      (block_guard == `BLOCK_ALL) ||
      ((block_guard == `BLOCK_HALF) && addr[AW-1]) || // R24
      ((block_guard == `BLOCK_QUARTER) && (&addr[AW-1:AW-2])); // R21

  // driven only while actually shifting out read data
  assign so_oe_n = !(live && (state == S_OUT) && out_on); // R2 R25 R9
  assign so_out = so_q;

  // two-flop synchronisers; the first stage feeds nothing else
  always @(posedge clk) begin
    if (rst) begin
      pin_meta <= 5'h1B;
      pin_sync <= 5'h1B;
    end else begin
      pin_meta <= {cs_n, sck, si, hold_n, wp_n};
      pin_sync <= pin_meta;
    end
  end

  // edge history of the synchronised pins
  always @(posedge clk) begin
    if (rst) begin
      sck_d <= 1'b1;
      cs_d <= 1'b1;
      wp_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      cs_d <= cs_s;
      wp_d <= wp_s;
    end
  end

  // pause follows the pin only in a clock-low phase
  always @(posedge clk) begin
    if (rst || !selected) begin
      hold_act <= 1'b0; // R8
    end else if (!sck_s) begin
      hold_act <= !hold_s; // R8 R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence control, status register and write cycle timer
  always @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      omode <= M_STATUS;
      pend <= P_NONE;
      sreg <= 8'h00;
      bcnt <= 3'h0;
      acnt <= 2'h0;
      addr <= {AW{1'b0}};
      obuf <= 8'h00;
      ocnt <= 3'h0;
      out_on <= 1'b0;
      so_q <= 1'b0;
      wp_fell <= 1'b0;
      sr_full <= 1'b0;
      sr_new <= 8'h00;
      wr_any <= 1'b0;
      guard_enable_bit <= `SR_GUARD_RESET; // R22
      {block_guard_hi, block_guard_lo} <= `SR_BLOCK_RESET; // R21
      write_latch <= `SR_LATCH_RESET; // R20
      busy <= 1'b0;
      wcnt <= 32'h0;
      rd_req <= 1'b0;
      array_commit <= 1'b0;
      array_abort <= 1'b0;
      push <= 1'b0;
      push_byte <= 8'h00;
      push_addr <= {AW{1'b0}};
    end else begin
      rd_req <= 1'b0;
      array_commit <= 1'b0;
      array_abort <= 1'b0;
      push <= 1'b0;
      // internal cycle runs on regardless of pins or pause
      if (busy) begin
        if (wcnt == 32'h0) begin
          busy <= 1'b0; // R7
          write_latch <= 1'b0;
        end else begin
          wcnt <= wcnt - 1'b1;
        end
      end
      if (selected && wp_d && !wp_s && guard_enable_bit) begin
        wp_fell <= 1'b1; // R13
      end
      if (cs_fall) begin
        // a falling select always restarts, even after a rejected opcode
        state <= S_OPC; // R5 R6
        bcnt <= 3'h0;
        acnt <= 2'h0;
        ocnt <= 3'h0;
        out_on <= 1'b0;
        pend <= P_NONE;
        // a protect fall in the very restart cycle must not be lost
        wp_fell <= wp_d && !wp_s && guard_enable_bit; // R13
        sr_full <= 1'b0;
        wr_any <= 1'b0;
      end else if (cs_rise) begin
        state <= S_IDLE;
        if (hold_act) begin
          write_latch <= 1'b0; // R11
          if (wr_any) begin
            array_abort <= 1'b1; // R11
          end
        end else begin
          if (pend == P_SET) begin
            write_latch <= 1'b1; // R15
          end else if (pend == P_CLEAR) begin
            write_latch <= 1'b0; // R15
          end
          // cancel if guarded or protect pin fell while selected
          if (sr_full && write_latch && !hw_guard && !wp_fell) begin
            guard_enable_bit <= sr_new[`SR_GUARD_BIT]; // R23
            block_guard_hi <= sr_new[`SR_BLOCK_HI]; // R23
            block_guard_lo <= sr_new[`SR_BLOCK_LO]; // R23
            busy <= 1'b1;
            wcnt <= WRITE_CYCLES - 1;
          end
          if (wr_any) begin
            array_commit <= 1'b1;
            busy <= 1'b1;
            wcnt <= WRITE_CYCLES - 1;
          end
        end
      end else if (sck_rise) begin
        case (state)
          S_OPC, S_ADDR, S_WDATA, S_SRIN: begin
            sreg <= in_byte; // R3
            bcnt <= bcnt + 1'b1;
            if (state == S_ADDR) begin
              addr <= {addr[AW-2:0], si_s}; // R3
            end
          end
          default: begin
            bcnt <= bcnt;
          end
        endcase
        if (bcnt == `BITS_PER_BYTE_M1) begin
          case (state)
            S_OPC: begin
              // while busy the two status reads take effect, and the latch commands still take effect at deselect; write and read commands are rejected
              case (in_byte)
                `OPC_STATUS_READ: begin
                  state <= S_OUT; // R14
                  omode <= M_STATUS;
                end
                `OPC_LOW_POWER_POLL: begin
                  state <= S_OUT; // R14
                  omode <= M_POLL;
                end
                `OPC_LATCH_SET: begin
                  state <= busy ? S_REJECT : S_DONE; // R15
                  pend <= P_SET;
                end
                `OPC_LATCH_CLEAR: begin
                  state <= busy ? S_REJECT : S_DONE; // R15
                  pend <= P_CLEAR;
                end
                `OPC_STATUS_WRITE: begin
                  state <= (busy || hw_guard) ? S_REJECT : S_SRIN; // R16 R12
                end
                `OPC_ARRAY_READ: begin
                  state <= busy ? S_REJECT : S_ADDR; // R17
                  omode <= M_ARRAY;
                end
                `OPC_ARRAY_WRITE, `OPC_ARRAY_WRITE_ALT: begin
                  state <= (busy || !write_latch) ? S_REJECT : S_ADDR; // R17
                  omode <= M_STATUS;
                end
                default: begin
                  state <= S_REJECT; // R6
                end
              endcase
            end
            S_ADDR: begin
              acnt <= acnt + 1'b1;
              if (acnt == `ADDR_BYTES_M1) begin
                state <= (omode == M_ARRAY) ? S_OUT : S_WDATA;
                rd_req <= (omode == M_ARRAY);
              end
            end
            S_WDATA: begin
              // guarded bytes are dropped; address still advances
              push <= !addr_guarded;
              push_byte <= in_byte;
              push_addr <= addr;
              wr_any <= wr_any || !addr_guarded;
              addr <= addr + 1'b1;
            end
            S_SRIN: begin
              sr_new <= in_byte;
              sr_full <= 1'b1;
              state <= S_DONE;
            end
            default: begin
              state <= state;
            end
          endcase
        end
      end else if (sck_fall && (state == S_OUT)) begin
        // status is resampled every byte, array reads fetch ahead
        out_on <= 1'b1; // R4
        ocnt <= ocnt + 1'b1;
        if (ocnt == 3'h0) begin
          so_q <= out_src[7]; // R4
          obuf <= {out_src[6:0], 1'b0};
          if (omode == M_ARRAY) begin
            addr <= addr + 1'b1;
            rd_req <= 1'b1;
          end
        end else begin
          so_q <= obuf[7];
          obuf <= {obuf[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array write bytes wait here for the array sequencer
  sync_fifo #(
    .WIDTH(AW + 8),
    .DEPTH(BUF_DEPTH),
    .PW(BUF_PW)
  ) u_wbuf (
    .clk(clk),
    .rst(rst),
    .clear(array_abort),
    .in_data({push_addr, push_byte}),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(wr_valid),
    .out_ready(wr_ready)
  );

  // the master cannot be stalled, so fullness is reported outward
  assign wbuf_ready = fifo_in_ready;
  assign wr_addr = fifo_out[AW+7:8];
  assign wr_data = fifo_out[7:0];
endmodule

// [shared/spi_eeprom_defines.vh]
`ifndef SPI_EEPROM_DEFINES_VH
`define SPI_EEPROM_DEFINES_VH

// opcodes
`define OPC_STATUS_READ 8'h05
`define OPC_LOW_POWER_POLL 8'h08
`define OPC_LATCH_SET 8'h06
`define OPC_LATCH_CLEAR 8'h04
`define OPC_STATUS_WRITE 8'h01
`define OPC_ARRAY_READ 8'h03
`define OPC_ARRAY_WRITE 8'h02
`define OPC_ARRAY_WRITE_ALT 8'h07

// status_flags field positions
`define SR_GUARD_BIT 7
`define SR_SPARE_HI 6
`define SR_SPARE_LO 4
`define SR_BLOCK_HI 3
`define SR_BLOCK_LO 2
`define SR_LATCH_BIT 1
`define SR_BUSY_BIT 0

// reset values of the writable fields
`define SR_GUARD_RESET 1'b0
`define SR_BLOCK_RESET 2'h0
`define SR_LATCH_RESET 1'b0

// block guard encodings
`define BLOCK_NONE 2'h0
`define BLOCK_QUARTER 2'h1
`define BLOCK_HALF 2'h2
`define BLOCK_ALL 2'h3

// framing
`define BITS_PER_BYTE_M1 3'h7
`define ADDR_BYTES_M1 2'h2
`define POLL_BUSY_BYTE 8'hFF
`define POLL_READY_BYTE 8'h00

// internal write cycle time
`define WRITE_TIME_US 10000
`define CLK_MHZ 25

`endif

// [verification/serial_eeprom_spi_front_end_tb.sv]
`timescale 1ns/10ps
`include "spi_eeprom_defines.vh"
module serial_eeprom_spi_front_end_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wp_n = 1'b1;
  reg wr_ready = 1'b0;
  reg [7:0] rd_data = 8'h00;
  wire cs_n, sck, si, hold_n, so_out, so_oe_n;
  wire rd_req, wr_valid, wbuf_ready, array_commit, array_abort, busy_flag;
  wire [17:0] rd_addr, wr_addr;
  wire [7:0] wr_data;
  wire [1:0] block_guard;
  integer miscompares = 0;
  integer checks_done = 0;
  integer commits = 0;
  integer aborts = 0;
  logic [7:0] popped [$];
  reg [17:0] first_addr;
  reg [7:0] r, v;
  integer i;

  always #20 clk = ~clk;

  spi_master_model m (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so_out(so_out), .so_oe_n(so_oe_n));

  spi_eeprom_front #(.WRITE_CYCLES(600)) DUT (.clk(clk), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so_out(so_out), .so_oe_n(so_oe_n), .rd_addr(rd_addr),
    .rd_req(rd_req), .rd_data(rd_data), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wbuf_ready(wbuf_ready), .array_commit(array_commit),
    .array_abort(array_abort), .busy_flag(busy_flag),
    .block_guard(block_guard));

  // array stand-in: byte derived from address, pops and pulses logged
  always @(posedge clk) begin
    if (rd_req)
      rd_data <= rd_addr[7:0] ^ 8'h3C;
    if (wr_valid && wr_ready) begin
      if (popped.size() == 0)
        first_addr <= wr_addr;
      popped.push_back(wr_data);
    end
    if (array_commit)
      commits <= commits + 1;
    if (array_abort)
      aborts <= aborts + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task op1(input [7:0] op);
    m.sel;
    m.xfer(op, r);
    m.desel;
  endtask

  // opcode plus one byte; returns what came back in the second byte
  task op2(input [7:0] op, input [7:0] d, output [7:0] q);
    m.sel;
    m.xfer(op, r);
    m.xfer(d, q);
    m.desel;
  endtask

  task wait_idle;
    integer n;
    n = 0;
    while (busy_flag !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n = n + 1;
    end
    if (n == 3000) begin
      miscompares = miscompares + 1;
      complete_run;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task s_reset_and_latch;
    check({7'h0, so_oe_n}, 8'h01);
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h00);
    op1(`OPC_LATCH_SET);
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h02);
    op1(`OPC_LATCH_CLEAR);
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h00);
  endtask

  task s_status_write;
    op1(`OPC_LATCH_SET);
    op2(`OPC_STATUS_WRITE, 8'hFF, v);
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'hFF);
    op2(`OPC_LOW_POWER_POLL, 8'h00, v);
    check(v, 8'hFF);
    check({6'h0, block_guard}, 8'h03);
    wait_idle;
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h8C);
    op2(`OPC_LOW_POWER_POLL, 8'h00, v);
    check(v, 8'h00);
  endtask

  task s_protect;
    @(posedge clk);
    wp_n <= 1'b0;
    op1(`OPC_LATCH_SET);
    op2(`OPC_STATUS_WRITE, 8'h00, v);
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h8E);
    wp_n <= 1'b1;
    m.sel;
    m.xfer(`OPC_STATUS_WRITE, r);
    wp_n <= 1'b0;
    m.xfer(8'h00, r);
    wp_n <= 1'b1;
    m.tick(4);
    m.desel;
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h8E);
    op2(`OPC_STATUS_WRITE, 8'h00, v);
    wait_idle;
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h00);
  endtask

  task s_invalid_and_read;
    m.sel;
    m.xfer(8'hA5, r);
    m.xfer(`OPC_LATCH_SET, r);
    check(m.hz, 8'hFF);
    m.desel;
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h00);
    m.sel;
    m.xfer(`OPC_ARRAY_READ, r);
    m.xfer(8'h00, r);
    m.xfer(8'h01, r);
    m.xfer(8'h23, r);
    m.xfer(8'h00, v);
    check(v, 8'h1F);
    m.xfer(8'h00, v);
    check(v, 8'h18);
    m.desel;
  endtask

  // fill the buffer past full with the drain stalled, then empty it
  task s_fill_and_drain;
    integer n;
    op1(`OPC_LATCH_SET);
    m.sel;
    m.xfer(`OPC_ARRAY_WRITE, r);
    m.xfer(8'h00, r);
    m.xfer(8'h00, r);
    m.xfer(8'h40, r);
    for (i = 0; i < 34; i = i + 1)
      m.xfer(i[7:0], r);
    check({7'h0, wbuf_ready}, 8'h00);
    m.desel;
    check(commits[7:0], 8'h01);
    wr_ready <= 1'b1;
    n = 0;
    while (wr_valid !== 1'b0 && n < 100) begin
      @(posedge clk);
      n = n + 1;
    end
    if (n == 100) begin
      miscompares = miscompares + 1;
      complete_run;
    end
    n = popped.size();
    check(n[7:0], 8'h20);
    check(popped[0], 8'h00);
    check(popped[31], 8'h1F);
    check(first_addr[7:0], 8'h40);
    wait_idle;
  endtask

  // half guard: a byte for the upper half is dropped, nothing commits
  task s_half_guard;
    wr_ready <= 1'b0;
    op1(`OPC_LATCH_SET);
    op2(`OPC_STATUS_WRITE, 8'h08, v);
    wait_idle;
    check({6'h0, block_guard}, 8'h02);
    op1(`OPC_LATCH_SET);
    m.sel;
    m.xfer(`OPC_ARRAY_WRITE, r);
    m.xfer(8'h02, r);
    m.xfer(8'h00, r);
    m.xfer(8'h00, r);
    m.xfer(8'h55, r);
    m.desel;
    check({7'h0, wr_valid}, 8'h00);
    check(commits[7:0], 8'h01);
    op2(`OPC_STATUS_WRITE, 8'h00, v);
    wait_idle;
  endtask

  // deselect during pause drops the queued byte and the latch
  task s_pause_abort;
    wr_ready <= 1'b0;
    op1(`OPC_LATCH_SET);
    m.sel;
    m.xfer(`OPC_ARRAY_WRITE_ALT, r);
    m.xfer(8'h00, r);
    m.xfer(8'h00, r);
    m.xfer(8'h00, r);
    m.xfer(8'hAB, r);
    m.pause(1'b0);
    m.desel;
    check(aborts[7:0], 8'h01);
    check({7'h0, wr_valid}, 8'h00);
    m.pause(1'b1);
    op2(`OPC_STATUS_READ, 8'h00, v);
    check(v, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    m.tick(4);
    s_reset_and_latch;
    s_status_write;
    s_protect;
    s_invalid_and_read;
    s_fill_and_drain;
    s_half_guard;
    s_pause_abort;
    complete_run;
  end
endmodule

// [verification/spi_eeprom_front_properties.sv]
`timescale 1ns/10ps
module spi_eeprom_front_properties #(
  parameter WRITE_CYCLES = 20
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // serial pins
  input wire cs_n,
  input wire hold_n,
  input wire so_oe_n,
  // array side
  input wire rd_req,
  input wire wr_valid,
  input wire wbuf_ready,
  input wire array_commit,
  input wire array_abort,
  input wire busy_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // length of the current busy run, read in the cycle busy falls
  reg [31:0] busy_cnt;
  always @(posedge clk) begin
    if (rst || !busy_flag)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= busy_cnt + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  a_idle_hiz: assert property (cs_n [*6] |-> so_oe_n)
    else $error("output driven while deselected");
  a_oe_selected: assert property (!so_oe_n |-> !$past(cs_n, 5))
    else $error("output driven long after deselect");
  a_pause_hiz: assert property ((!cs_n && !hold_n) [*8] |-> so_oe_n)
    else $error("output driven in pause");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> so_oe_n && !busy_flag && !array_commit && wbuf_ready)
    else $error("outputs not at reset values");
  a_busy_length: assert property (
    $fell(busy_flag) |-> busy_cnt == WRITE_CYCLES)
    else $error("busy run has wrong length");
  a_commit_busy: assert property (
    array_commit |-> cs_n && !array_abort ##[0:2] busy_flag)
    else $error("commit without deselect or busy");
  a_commit_pulse: assert property (array_commit |=> !array_commit)
    else $error("commit longer than one cycle");
  a_abort_pulse: assert property (
    array_abort |-> cs_n ##1 !array_abort && !busy_flag)
    else $error("abort not a clean pulse");
  a_read_pulse: assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  a_full_nonempty: assert property (!wbuf_ready |-> wr_valid)
    else $error("buffer full but empty");

  c_commit: cover property (array_commit);
  c_abort: cover property (array_abort);
  c_full: cover property (!wbuf_ready);
endmodule

bind spi_eeprom_front spi_eeprom_front_properties #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_props (
  .clk(clk), .rst(rst), .cs_n(cs_n), .hold_n(hold_n), .so_oe_n(so_oe_n),
  .rd_req(rd_req), .wr_valid(wr_valid), .wbuf_ready(wbuf_ready),
  .array_commit(array_commit), .array_abort(array_abort),
  .busy_flag(busy_flag)
);

// [verification/spi_master_model.sv]
`timescale 1ns/10ps
module spi_master_model (
  // bench clock
  input wire clk,
  // serial pins
  output reg cs_n,
  output reg sck,
  output reg si,
  output reg hold_n,
  input wire so_out,
  input wire so_oe_n
);
  // per-bit record of the enable, 1 where the line was not driven
  reg [7:0] hz;
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // deselected, the data line never shows a stale bit
  always @(posedge clk) begin
    if (cs_n)
      si <= ~si;
  end

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  // only the master opens and closes frames
  task sel;
    @(posedge clk);
    cs_n <= 1'b0;
    tick(4);
  endtask

  task desel;
    @(posedge clk);
    cs_n <= 1'b1;
    tick(6);
  endtask

  // mode 3: drive on the fall, sample on the rise; an undriven line
  // shows the inverse, so a stale bit never passes for data
  task xfer(input [7:0] d, output [7:0] q);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      @(posedge clk);
      sck <= 1'b0;
      si <= d[i];
      tick(3);
      @(posedge clk);
      sck <= 1'b1;
      #1;
      q[i] = so_oe_n ? ~so_out : so_out;
      hz[i] = so_oe_n;
      tick(3);
    end
  endtask

  // hold moves while the clock is high, so it acts at the next low
  task pause(input v);
    @(posedge clk);
    hold_n <= v;
    tick(2);
    sck <= 1'b0;
    tick(8);
    sck <= 1'b1;
    tick(4);
  endtask
endmodule
